/* hdl/stm_params.svh */
// Offsets, field positions, reset values and divider counts of the timer.
// Included by the synchroniser, prescaler and timer sources and the bench; holds definitions only.
`ifndef STM_PARAMS_SVH
`define STM_PARAMS_SVH

// ----------------------------------------
// Register byte addresses on the bus
// ----------------------------------------
`define STM_OFS_CTL0 8'h00
`define STM_OFS_CTL1 8'h04
`define STM_OFS_CNTL 8'h08
`define STM_OFS_CNTH 8'h0c
`define STM_OFS_CMAL 8'h10
`define STM_OFS_CMAH 8'h14

// ----------------------------------------
// Reset values
// ----------------------------------------
`define STM_CTL0_RST 8'h00
`define STM_CTL1_RST 8'h00
`define STM_CNT_RST 10'h000

// ----------------------------------------
// timer_control_0 fields
// ----------------------------------------
`define STM_PAUSE_BIT 7
`define STM_CKSEL_MSB 6
`define STM_CKSEL_LSB 4
`define STM_RUN_BIT 3
`define STM_RP_MSB 2
`define STM_RP_LSB 0

// ----------------------------------------
// timer_control_1 fields
// ----------------------------------------
`define STM_MODE_MSB 7
`define STM_MODE_LSB 6
`define STM_IO_MSB 5
`define STM_IO_LSB 4
`define STM_OC_BIT 3
`define STM_POL_BIT 2
`define STM_DPX_BIT 1
`define STM_CCLR_BIT 0

// ----------------------------------------
// Prescaler terminal counts and pin slots
// ----------------------------------------
`define STM_DIV4_LAST 2'h3
`define STM_DIV16_LAST 4'hf
`define STM_DIV64_LAST 6'h3f
`define STM_PIN_EXT 0
`define STM_PIN_CAP 1
`define STM_PIN_SUB 2

`endif

/* hdl/stm_pkg.sv */
// Types shared by the timer modules.
// Field positions and counts live in stm_params.svh.
package stm_pkg;

    typedef enum logic [1:0] {
        STM_MODE_CMP = 2'h0,
        STM_MODE_CAP = 2'h1,
        STM_MODE_PWM = 2'h2,
        STM_MODE_TMR = 2'h3
    } stm_mode_t;

    typedef enum logic [2:0] {
        STM_CK_SYS4 = 3'h0,
        STM_CK_SYS = 3'h1,
        STM_CK_H16 = 3'h2,
        STM_CK_H64 = 3'h3,
        STM_CK_SUB0 = 3'h4,
        STM_CK_SUB1 = 3'h5,
        STM_CK_EXTR = 3'h6,
        STM_CK_EXTF = 3'h7
    } stm_cksel_t;

    typedef struct packed {
        logic [7:0] ctl0;
        logic [7:0] ctl1;
        logic [9:0] cnt;
        logic [9:0] cca;
        logic [7:0] buffer;
        logic run_d;
        logic lvl;
        logic pin_p;
        logic pin_n;
        logic int_a;
        logic int_p;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } stm_core_t;

    typedef struct packed {
        logic [2:0] s1;
        logic [2:0] s2;
        logic [2:0] s3;
    } stm_sync_t;

    typedef struct packed {
        logic [5:0] div;
        logic tick;
    } stm_presc_t;

endpackage : stm_pkg

/* hdl/stm_presc.sv */
// Counter clock enable generator for the timer.
// Assumes the high clock equals pclk and pin edges come pre-synchronised.
`timescale 1ns/1ns
`default_nettype none
`include "stm_params.svh"

module stm_presc
    import stm_pkg::*;
(
    input wire logic pclk, // System clock
    input wire logic presetn, // Async reset, active low
    stm_tick_if.presc tk // Select in, tick out
);
    stm_presc_t st;
    stm_presc_t next_st;

    // RQ14 clock source select
    always_comb begin
        next_st = st;
        next_st.div = st.div + 6'h01;
        unique case (tk.clk_sel)
            STM_CK_SYS4: next_st.tick = (st.div[1:0] == `STM_DIV4_LAST);
            STM_CK_SYS: next_st.tick = 1'b1;
            STM_CK_H16: next_st.tick = (st.div[3:0] == `STM_DIV16_LAST);
            STM_CK_H64: next_st.tick = (st.div == `STM_DIV64_LAST);
            STM_CK_SUB0, STM_CK_SUB1: next_st.tick = tk.sub_rise;
            STM_CK_EXTR: next_st.tick = tk.ext_rise;
            STM_CK_EXTF: next_st.tick = tk.ext_fall;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign tk.tick = st.tick;
endmodule : stm_presc

`default_nettype wire

/* hdl/stm_sync.sv */
// Two-flop synchroniser and edge detector for the timer's input pins.
// Assumes raw pins are asynchronous to pclk.
`timescale 1ns/1ns
`default_nettype none
`include "stm_params.svh"

module stm_sync
    import stm_pkg::*;
(
    input wire logic pclk, // System clock
    input wire logic presetn, // Async reset, active low
    input wire logic [2:0] pins, // Raw ext clock, capture, subclock
    stm_tick_if.sync tk // Edge pulses out
);
    stm_sync_t st;
    stm_sync_t next_st;
    logic [2:0] rise;
    logic [2:0] fall;

    always_comb begin
        next_st = st;
        next_st.s1 = pins;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // Edges only from the second stage on; first stage may be metastable
    genvar i;
    generate
        for (i = 0; i < 3; i++) begin : g_edge
            assign rise[i] = st.s2[i] & ~st.s3[i];
            assign fall[i] = ~st.s2[i] & st.s3[i];
        end
    endgenerate

    // RQ2 pin edge detect
    assign tk.ext_rise = rise[`STM_PIN_EXT];
    assign tk.ext_fall = fall[`STM_PIN_EXT];
    // RQ3 capture edges
    assign tk.cap_rise = rise[`STM_PIN_CAP];
    assign tk.cap_fall = fall[`STM_PIN_CAP];
    assign tk.sub_rise = rise[`STM_PIN_SUB];
endmodule : stm_sync

`default_nettype wire

/* hdl/stm_tick_if.sv */
// Carrier between the timer core, its pin synchroniser and its prescaler.
// All signals are on pclk.
`timescale 1ns/1ns
`default_nettype none

interface stm_tick_if;
    logic ext_rise;
    logic ext_fall;
    logic cap_rise;
    logic cap_fall;
    logic sub_rise;
    logic [2:0] clk_sel;
    logic tick;

    modport sync (output ext_rise, ext_fall, cap_rise, cap_fall, sub_rise);
    modport presc (input ext_rise, ext_fall, sub_rise, clk_sel, output tick);
    modport core (input tick, ext_rise, cap_rise, cap_fall, output clk_sel);
endinterface : stm_tick_if

`default_nettype wire

/* hdl/stm_timer.sv */
// 10-bit standard timer: APB registers, counter, comparators, pin logic.
// Assumes an APB master on pclk; pins may be asynchronous.
//
// What this block does
// RQ1: Comparator A and period comparator each raise their own interrupt on match; the period one is dropped when A clears, except in pulse output mode.
// RQ2: External clock pin counts on chosen edge, and triggers single pulse.
// RQ3: Capture pin edge is rising, falling or both, per pin-function field.
// RQ4: Second output pin is always the inverse of the primary output.
// RQ5: Compare match output mode forces high, low or toggles on match.
// RQ6: Writing a compare low byte only loads the shared 8-bit buffer.
// RQ7: Writing compare high byte stores it and copies buffer into low byte.
// RQ8: Reading a high byte copies its low byte into buffer; low read returns buffer.
// RQ9: Software writes low before high, reads high before low.
// RQ10: Core is a 10-bit up-counter on the selected clock.
// RQ11: Period compares 3 bits to counter 9..7; comparator A all 10 bits.
// RQ12: Counter not writable; cleared on run rise, overflow or selected match.
// RQ13: Pause bit halts counting, keeps value, resumes from it.
// RQ14: Clock select picks sys/4, sys, high/16, high/64, sub, pin rise, fall.
// RQ15: Clearing run stops counting and keeps the counter value.
// RQ16: Run rising returns the output to its initial level in output modes.
// RQ17: Period match every setting times 128 clocks; zero means 1024.
// RQ18: With clear select zero a period match zeroes the counter; in pulse output mode dpx picks the clear source instead.
// RQ19: Counter read-only pair, comparator A read/write pair, two control regs.
// RQ20: Mode field picks compare output, capture, pulse output or timer.
// RQ21: With clear select one a comparator A match zeroes the counter; capture mode always clears on period, pulse output mode uses dpx.
//
// The address map and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "stm_params.svh"

module stm_timer
    import stm_pkg::*;
(
    input wire logic pclk, // System clock, 250 MHz
    input wire logic presetn, // Async reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction, 1 write
    input wire logic [7:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error, unmapped address
    input wire logic external_clock_input, // Count clock or trigger pin
    input wire logic capture_input_pin, // Capture pin
    input wire logic sub_clock_pin, // Subclock source
    output logic primary_output_pin, // Timer output
    output logic inverted_output_pin, // Inverse of timer output
    output logic irq_compare_a, // Comparator A event pulse
    output logic irq_period // Period comparator event pulse
);
    // ----------------------------------------
    // Submodules
    // ----------------------------------------
    stm_tick_if tk ();

    stm_sync u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .pins({sub_clock_pin, capture_input_pin, external_clock_input}),
        .tk(tk.sync)
    );

    stm_presc u_presc (
        .pclk(pclk),
        .presetn(presetn),
        .tk(tk.presc)
    );

    // ----------------------------------------
    // Decode of state
    // ----------------------------------------
    stm_core_t st;
    stm_core_t next_st;
    logic run;
    logic pause;
    logic [2:0] rp;
    stm_mode_t mode;
    logic [1:0] io;
    logic oc;
    logic pol;
    logic dpx;
    logic cclr;
    logic run_rise;
    logic counting;
    logic [9:0] p_last;
    logic a_hit;
    logic p_hit;
    logic clr_on_a;
    logic cnt_clr;
    logic cap_hit;
    logic duty_hit;
    logic setup;
    logic access;
    logic mapped;

    assign run = st.ctl0[`STM_RUN_BIT];
    assign pause = st.ctl0[`STM_PAUSE_BIT];
    assign rp = st.ctl0[`STM_RP_MSB:`STM_RP_LSB];
    assign mode = stm_mode_t'(st.ctl1[`STM_MODE_MSB:`STM_MODE_LSB]);
    assign io = st.ctl1[`STM_IO_MSB:`STM_IO_LSB];
    assign oc = st.ctl1[`STM_OC_BIT];
    assign pol = st.ctl1[`STM_POL_BIT];
    assign dpx = st.ctl1[`STM_DPX_BIT];
    assign cclr = st.ctl1[`STM_CCLR_BIT];
    assign tk.clk_sel = st.ctl0[`STM_CKSEL_MSB:`STM_CKSEL_LSB];

    assign run_rise = run & ~st.run_d;
    // RQ13 pause gate
    // RQ15 run gate
    assign counting = run & ~pause & tk.tick;

    // ----------------------------------------
    // Comparators
    // ----------------------------------------
    // RQ11 period compare
    // RQ17 multiples of 128; zero wraps to all ones
    assign p_last = {rp, 7'h00} - 10'h001;
    assign p_hit = counting & (st.cnt == p_last);
    // RQ11 comparator A, zero never matches
    assign a_hit = counting & (st.cca != 10'h000) & (st.cnt + 10'h001 == st.cca);

    // RQ20 clear source by mode; capture always runs on period
    assign clr_on_a = (mode == STM_MODE_PWM) ? dpx :
                      (mode == STM_MODE_CAP) ? 1'b0 : cclr;
    // RQ18 period clear
    // RQ21 comparator A clear
    assign cnt_clr = clr_on_a ? a_hit : p_hit;
    assign duty_hit = dpx ? p_hit : a_hit;

    // RQ3 capture edge choice
    always_comb begin
        cap_hit = 1'b0;
        if (mode == STM_MODE_CAP && run) begin
            unique case (io)
                2'h0: cap_hit = tk.cap_rise;
                2'h1: cap_hit = tk.cap_fall;
                2'h2: cap_hit = tk.cap_rise | tk.cap_fall;
                2'h3: cap_hit = 1'b0;
            endcase
        end
    end

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    assign setup = psel & ~penable;
    assign access = psel & penable & st.pready;
    // RQ19 register map
    assign mapped = (paddr == `STM_OFS_CTL0) || (paddr == `STM_OFS_CTL1) ||
                    (paddr == `STM_OFS_CNTL) || (paddr == `STM_OFS_CNTH) ||
                    (paddr == `STM_OFS_CMAL) || (paddr == `STM_OFS_CMAH);

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        next_st = st;
        next_st.int_a = 1'b0;
        next_st.int_p = 1'b0;
        next_st.pready = 1'b1;
        next_st.run_d = run;

        // Read data and buffer latch at the setup edge, so high and low
        // byte of the counter are taken in the same cycle.
        if (setup) begin
            next_st.pslverr = ~mapped;
            next_st.prdata = 32'h0000_0000;
            if (!pwrite) begin
                unique case (paddr)
                    `STM_OFS_CTL0: next_st.prdata[7:0] = st.ctl0;
                    `STM_OFS_CTL1: next_st.prdata[7:0] = st.ctl1;
                    // RQ8 low read from buffer
                    `STM_OFS_CNTL, `STM_OFS_CMAL: next_st.prdata[7:0] = st.buffer;
                    `STM_OFS_CNTH: begin
                        // RQ8 high read latches low
                        next_st.prdata[1:0] = st.cnt[9:8];
                        next_st.buffer = st.cnt[7:0];
                    end
                    `STM_OFS_CMAH: begin
                        next_st.prdata[1:0] = st.cca[9:8];
                        next_st.buffer = st.cca[7:0];
                    end
                    default: next_st.prdata = 32'h0000_0000;
                endcase
            end
        end

        // Writes take effect at the completing edge
        if (access && pwrite && !st.pslverr) begin
            unique case (paddr)
                `STM_OFS_CTL0: next_st.ctl0 = pwdata[7:0];
                `STM_OFS_CTL1: next_st.ctl1 = pwdata[7:0];
                // RQ6 low write to buffer only
                `STM_OFS_CMAL: next_st.buffer = pwdata[7:0];
                // RQ7 high write commits pair
                // RQ9 relies on low written first
                `STM_OFS_CMAH: next_st.cca = {pwdata[1:0], st.buffer};
                // RQ12 counter has no write path
                default: next_st.ctl0 = next_st.ctl0;
            endcase
        end

        // RQ10 up-counter
        // RQ12 clear on run rise or match
        if (run_rise) begin
            next_st.cnt = `STM_CNT_RST;
        end else if (counting) begin
            next_st.cnt = cnt_clr ? `STM_CNT_RST : st.cnt + 10'h001;
        end

        // RQ1 interrupt sources; period flag dropped when A clears, except in pulse output mode
        next_st.int_a = a_hit | cap_hit;
        next_st.int_p = p_hit & (~clr_on_a | (mode == STM_MODE_PWM));

        // Capture overrides a bus write to the compare pair
        if (cap_hit) begin
            next_st.cca = st.cnt;
        end

        unique case (mode)
            STM_MODE_CMP: begin
                // RQ16 initial level on run rise
                if (run_rise) begin
                    next_st.lvl = oc;
                end else if (a_hit) begin
                    // RQ5 match action
                    unique case (io)
                        2'h0: next_st.lvl = st.lvl;
                        2'h1: next_st.lvl = 1'b0;
                        2'h2: next_st.lvl = 1'b1;
                        2'h3: next_st.lvl = ~st.lvl;
                    endcase
                end
            end
            STM_MODE_PWM: begin
                // RQ4 waveform on primary output; oc is active level
                unique case (io)
                    2'h0: next_st.lvl = ~oc;
                    2'h1: next_st.lvl = oc;
                    2'h2: begin
                        // RQ16 restart at active level
                        if (run_rise || (counting && cnt_clr)) begin
                            next_st.lvl = oc;
                        end else if (duty_hit) begin
                            next_st.lvl = ~oc;
                        end
                    end
                    2'h3: begin
                        if (run_rise) begin
                            next_st.lvl = oc;
                        end else if (a_hit) begin
                            // Pulse ends, hardware stops the timer
                            next_st.lvl = ~oc;
                            next_st.ctl0[`STM_RUN_BIT] = 1'b0;
                        end else if (!run && tk.ext_rise) begin
                            // RQ2 pin trigger starts the pulse
                            next_st.ctl0[`STM_RUN_BIT] = 1'b1;
                        end
                    end
                endcase
            end
            STM_MODE_CAP, STM_MODE_TMR: next_st.lvl = st.lvl;
        endcase

        // RQ4 complementary pair
        next_st.pin_p = next_st.lvl ^ pol;
        next_st.pin_n = ~(next_st.lvl ^ pol);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
            st.ctl0 <= `STM_CTL0_RST;
            st.ctl1 <= `STM_CTL1_RST;
            st.pin_n <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign prdata = st.prdata;
    assign pready = st.pready;
    assign pslverr = st.pslverr;
    assign primary_output_pin = st.pin_p;
    assign inverted_output_pin = st.pin_n;
    assign irq_compare_a = st.int_a;
    assign irq_period = st.int_p;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_wr(logic [7:0] a);
        access && pwrite && !st.pslverr && paddr == a;
    endsequence

    property p_int_a;
        (a_hit || cap_hit) |=> irq_compare_a;
    endproperty
    a_int_a: assert property (p_int_a) else $error("compare A event lost"); // RQ1

    property p_int_p;
        (p_hit && !clr_on_a) |=> irq_period ##1 !irq_period || p_hit;
    endproperty
    a_int_p: assert property (p_int_p) else $error("period event lost"); // RQ1

    property p_pins;
        primary_output_pin != inverted_output_pin;
    endproperty
    a_pins: assert property (p_pins) else $error("output pair not inverse"); // RQ4

    property p_cmp_high;
        (mode == STM_MODE_CMP && io == 2'h2 && a_hit && !run_rise)
            |=> primary_output_pin == !$past(pol);
    endproperty
    a_cmp_high: assert property (p_cmp_high) else $error("output not forced high"); // RQ5

    property p_wr_low;
        (s_wr(`STM_OFS_CMAL) and mode != STM_MODE_CAP)
            |=> $stable(st.cca) && st.buffer == $past(pwdata[7:0]);
    endproperty
    a_wr_low: assert property (p_wr_low) else $error("low write leaked"); // RQ6

    property p_wr_high;
        (s_wr(`STM_OFS_CMAH) and mode != STM_MODE_CAP)
            |=> st.cca == {$past(pwdata[1:0]), $past(st.buffer)};
    endproperty
    a_wr_high: assert property (p_wr_high) else $error("pair not committed"); // RQ7

    property p_rd_high;
        (setup && !pwrite && paddr == `STM_OFS_CNTH)
            |=> st.buffer == $past(st.cnt[7:0])
                && prdata[1:0] == $past(st.cnt[9:8]);
    endproperty
    a_rd_high: assert property (p_rd_high) else $error("buffer not latched"); // RQ8

    property p_run_clear;
        $rose(run) |=> st.cnt == 10'h000;
    endproperty
    a_run_clear: assert property (p_run_clear) else $error("no clear on run"); // RQ12

    property p_pause;
        $past(pause) && $past(run) && !$past(run_rise) |-> $stable(st.cnt);
    endproperty
    a_pause: assert property (p_pause) else $error("counted while paused"); // RQ13

    property p_stop;
        !$past(run) |-> $stable(st.cnt);
    endproperty
    a_stop: assert property (p_stop) else $error("counted while off"); // RQ15

    property p_period;
        (p_hit && !clr_on_a && !run_rise) |=> st.cnt == 10'h000;
    endproperty
    a_period: assert property (p_period) else $error("period did not clear"); // RQ18

    property p_a_clear;
        (a_hit && clr_on_a && !run_rise) |=> st.cnt == 10'h000;
    endproperty
    a_a_clear: assert property (p_a_clear) else $error("A match did not clear"); // RQ21
endmodule : stm_timer

`default_nettype wire

/* test/stm_far.sv */
// Far side model: drives the timer's clock, capture and subclock pins.
// Assumes pclk from the bench; pins idle low, subclock runs free.
`timescale 1ns/1ns
`default_nettype none

module stm_far
    import stm_pkg::*;
(
    input wire logic pclk, // System clock
    output logic ext_pin, // Count clock or trigger pin
    output logic cap_pin, // Capture pin
    output logic sub_pin // Free running subclock
);
    initial begin
        ext_pin = 1'b0;
        cap_pin = 1'b0;
        sub_pin = 1'b0;
        forever begin
            repeat (8) @(posedge pclk);
            sub_pin <= ~sub_pin;
        end
    end

    task ext_pulses(input int n, input int half);
        repeat (n) begin
            repeat (half) @(posedge pclk);
            ext_pin <= 1'b1;
            repeat (half) @(posedge pclk);
            ext_pin <= 1'b0;
        end
    endtask : ext_pulses

    task cap_pulse(input int half);
        repeat (half) @(posedge pclk);
        cap_pin <= 1'b1;
        repeat (half) @(posedge pclk);
        cap_pin <= 1'b0;
    endtask : cap_pulse
endmodule : stm_far

`default_nettype wire

/* test/tb.sv */
// Self-checking bench for the timer over APB.
// Assumes pready answers without a fixed wait; far pins from stm_far.
`timescale 1ns/1ns
`default_nettype none
`include "stm_params.svh"

module tb
    import stm_pkg::*;
;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, ext, cap, sub, pout, nout, irq_a, irq_p;
    int error_cnt = 0;
    int checked = 0;
    int cyc = 0;
    int cnt_a = 0;
    int cnt_p = 0;

    stm_timer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .external_clock_input(ext), .capture_input_pin(cap),
        .sub_clock_pin(sub), .primary_output_pin(pout), .inverted_output_pin(nout),
        .irq_compare_a(irq_a), .irq_period(irq_p));
    stm_far far (.pclk(pclk), .ext_pin(ext), .cap_pin(cap), .sub_pin(sub));

    initial forever #2 pclk = ~pclk;

    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (irq_a === 1'b1) cnt_a <= cnt_a + 1;
        if (irq_p === 1'b1) cnt_p <= cnt_p + 1;
    end

    task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
             output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, {24'h0, d}, r, e);
    endtask : wr

    task rd(input logic [7:0] a, output logic [31:0] r);
        logic e;
        apb(1'b0, a, 32'h0, r, e);
    endtask : rd

    task rd_cnt(output logic [31:0] v);
        logic [31:0] h, l;
        rd(`STM_OFS_CNTH, h);
        rd(`STM_OFS_CNTL, l);
        v = {22'h0, h[1:0], l[7:0]};
    endtask : rd_cnt

    task wait_irq(input bit p, output int t);
        int n0;
        n0 = p ? cnt_p : cnt_a;
        while ((p ? cnt_p : cnt_a) == n0) @(posedge pclk);
        t = cyc;
    endtask : wait_irq

    task t_pair;
        logic [31:0] r;
        logic e;
        static logic [7:0] ofs [6] = '{`STM_OFS_CTL0, `STM_OFS_CTL1, `STM_OFS_CNTH,
            `STM_OFS_CNTL, `STM_OFS_CMAH, `STM_OFS_CMAL};
        foreach (ofs[i]) begin
            rd(ofs[i], r);
            chk("reset value", r, 32'h0);
        end
        chk("inverted pin", nout, {31'h0, ~pout});
        wr(`STM_OFS_CMAL, 8'h34);
        wr(`STM_OFS_CMAH, 8'h02);
        rd(`STM_OFS_CMAH, r);
        chk("compare high", r, 32'h2);
        rd(`STM_OFS_CMAL, r);
        chk("compare low", r, 32'h34);
        wr(`STM_OFS_CMAL, 8'h56);
        rd(`STM_OFS_CMAH, r);
        rd(`STM_OFS_CMAL, r);
        chk("low write held", r, 32'h34);
        wr(`STM_OFS_CNTL, 8'hff);
        rd_cnt(r);
        chk("counter not writable", r, 32'h0);
        apb(1'b0, 8'h18, 32'h0, r, e);
        chk("unmapped error", {31'h0, e}, 32'h1);
        $display("test pair done");
    endtask : t_pair

    task t_period;
        int t0, t1;
        logic [31:0] v0, v1;
        wr(`STM_OFS_CTL1, 8'hc0);
        for (int rp = 1; rp <= 3; rp += 2) begin
            wr(`STM_OFS_CTL0, 8'h00);
            wr(`STM_OFS_CTL0, 8'h18 | 8'(rp));
            wait_irq(1'b1, t0);
            wait_irq(1'b1, t1);
            chk("period span", t1 - t0, 128 * rp);
        end
        wr(`STM_OFS_CTL0, 8'h99);
        rd_cnt(v0);
        repeat (20) @(posedge pclk);
        rd_cnt(v1);
        chk("paused counter", v1, v0);
        wr(`STM_OFS_CTL0, 8'h19);
        repeat (20) @(posedge pclk);
        rd_cnt(v1);
        chk("resumed", {31'h0, v1 == v0}, 32'h0);
        wr(`STM_OFS_CTL0, 8'h11);
        rd_cnt(v0);
        repeat (20) @(posedge pclk);
        rd_cnt(v1);
        chk("run off holds", v1, v0);
        wr(`STM_OFS_CTL0, 8'h98);
        rd_cnt(v1);
        chk("run rise clears", v1, 32'h0);
        $display("test period done");
    endtask : t_period

    task t_cmp;
        int t0, t1;
        wr(`STM_OFS_CTL0, 8'h00);
        wr(`STM_OFS_CMAL, 8'h40);
        wr(`STM_OFS_CMAH, 8'h00);
        wr(`STM_OFS_CTL1, 8'h39);
        wr(`STM_OFS_CTL0, 8'h18);
        repeat (2) @(posedge pclk);
        chk("initial level", pout, 1'b1);
        wait_irq(1'b0, t0);
        repeat (3) @(posedge pclk);
        chk("toggled low", pout, 1'b0);
        wr(`STM_OFS_CTL1, 8'h29);
        wait_irq(1'b0, t1);
        repeat (3) @(posedge pclk);
        chk("forced high", pout, 1'b1);
        chk("inverted pin", nout, 1'b0);
        chk("clear on A span", t1 - t0, 64);
        $display("test compare done");
    endtask : t_cmp

    task t_ext;
        logic [31:0] v;
        for (int s = 6; s <= 7; s++) begin
            wr(`STM_OFS_CTL0, 8'h00);
            wr(`STM_OFS_CTL1, 8'hc0);
            wr(`STM_OFS_CTL0, 8'(s << 4) | 8'h08);
            far.ext_pulses(5, 4);
            repeat (8) @(posedge pclk);
            rd_cnt(v);
            chk("pin edge count", v, 32'h5);
        end
        $display("test ext done");
    endtask : t_ext

    task t_cap;
        int n;
        static int exp [4] = '{1, 1, 2, 0};
        for (int io = 0; io < 4; io++) begin
            wr(`STM_OFS_CTL0, 8'h00);
            wr(`STM_OFS_CMAL, 8'h00);
            wr(`STM_OFS_CMAH, 8'h00);
            wr(`STM_OFS_CTL1, 8'h40 | 8'(io << 4));
            wr(`STM_OFS_CTL0, 8'h08);
            n = cnt_a;
            far.cap_pulse(6);
            repeat (8) @(posedge pclk);
            chk("capture events", cnt_a - n, exp[io]);
        end
        $display("test capture done");
    endtask : t_cap

    task finish_test;
        $display("checked %0d error_cnt %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : finish_test

    // Whole run needs under 6000 cycles
    initial begin
        #80000;
        error_cnt++;
        finish_test();
    end

    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_pair();
        t_period();
        t_cmp();
        t_ext();
        t_cap();
        finish_test();
    end
endmodule : tb

`default_nettype wire
